// *** core/ppm_pin_mux.sv ***
// Functional notes
// - Each pin in the group is separately set as input or output.
// - Port C 12-15 and port D 4-7 reset to port function, input.
// - Port D bit 0 pin resets to test data input function.
// - Port D bit 1 pin resets to test data output, undriven in reset.
// - Port C bit 12 alternate carries serial channel one receive data.
// - Port D bit 5 alternate is external clock input for clock logic.
// - Test data input captured on rising test clock; host holds it stable.
// - Test data output driven only in shift-IR or shift-DR states.
// - Test data output changes on falling test clock; host samples rising.
// - Shared test clock pin resets to test clock function.
// - Mode select sequences the test port, sampled on rising test clock.
`timescale 1ns/1ns
`default_nettype none
module ppm_pin_mux
	import ppm_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	input  wire logic                 tck,
	input  wire logic                 tms,
	input  wire logic                 cfgWrite,
	input  wire logic [PIN_COUNT-1:0] cfgAlt,
	input  wire logic [PIN_COUNT-1:0] cfgDir,
	input  wire logic [PIN_COUNT-1:0] cfgOut,
	input  wire logic                 cfgTestClkSel,
	input  wire logic [PIN_COUNT-1:0] padIn,
	output logic      [PIN_COUNT-1:0] padOut,
	output logic      [PIN_COUNT-1:0] padOe,
	output logic      [PIN_COUNT-1:0] gpioIn,
	output logic      [PIN_COUNT-1:0] altState,
	output logic                      testClkSelect,
	output logic                      serialCh1ReceiveIn,
	output logic                      externalClockInput,
	output logic                      externalClockSelect
);
	logic [PIN_COUNT-1:0] alt_q;
	logic [PIN_COUNT-1:0] dir_q;
	logic [PIN_COUNT-1:0] out_q;
	logic [PIN_COUNT-1:0] meta_q;
	logic [PIN_COUNT-1:0] sync_q;
	logic [PIN_COUNT-1:0] gpioOut_q;
	logic [PIN_COUNT-1:0] gpioOe_q;
	logic [PIN_COUNT-1:0] gpioIn_q;
	logic                 tckSel_q;
	logic                 rxd_q;
	logic                 extClk_q;
	logic                 extSel_q;

	ppm_tap_if tapIf ();

	////////////////////////////////////////////////////////////////
	// Software configuration
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			alt_q    <= ALT_RESET;
			dir_q    <= DIR_RESET;
			out_q    <= OUT_RESET;
			tckSel_q <= TCK_SEL_RESET;
		end else if (cfgWrite) begin
			alt_q    <= cfgAlt;
			dir_q    <= cfgDir;
			out_q    <= cfgOut;
			tckSel_q <= cfgTestClkSel;
		end
	end

	////////////////////////////////////////////////////////////////
	// Pin inputs are asynchronous to clk
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= padIn;
			sync_q <= meta_q;
		end
	end

	// Port drive; peripheral pins lose the port driver one clk after their select is loaded
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gpioOut_q <= '0;
			gpioOe_q  <= '0;
			gpioIn_q  <= '0;
		end else begin
			gpioOut_q <= out_q & ~alt_q;
			gpioOe_q  <= dir_q & ~alt_q;
			gpioIn_q  <= sync_q & ~alt_q;
		end
	end

	// Peripheral routes; idle levels when the pin is in port mode
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rxd_q    <= RXD_IDLE;
			extClk_q <= CLK_IDLE;
			extSel_q <= 1'h0;
		end else begin
			rxd_q    <= alt_q[IDX_C12] ? sync_q[IDX_C12] : RXD_IDLE;
			extClk_q <= alt_q[IDX_D5] ? sync_q[IDX_D5] : CLK_IDLE;
			extSel_q <= alt_q[IDX_D5];
		end
	end

	////////////////////////////////////////////////////////////////
	// Test port: data input bypasses the clk synchroniser since
	// it is sampled on the test clock itself
	assign tapIf.tdi    = alt_q[IDX_D0] ? padIn[IDX_D0] : TDI_IDLE;
	assign tapIf.tdoSel = alt_q[IDX_D1];

	ppm_tap_ctrl uTap (
		.tck     (tck),
		.reset_n (reset_n),
		.tms     (tms),
		.tapIf   (tapIf.tap)
	);

	// Data output pin is a select between two flops, one per domain
	always_comb begin
		padOut = gpioOut_q;
		padOe  = gpioOe_q;
		if (alt_q[IDX_D1]) begin
			padOut[IDX_D1] = tapIf.tdo;
			padOe[IDX_D1]  = tapIf.tdoEn;
		end
	end

	assign gpioIn              = gpioIn_q;
	assign altState            = alt_q;
	assign testClkSelect       = tckSel_q;
	assign serialCh1ReceiveIn  = rxd_q;
	assign externalClockInput  = extClk_q;
	assign externalClockSelect = extSel_q;
endmodule
`default_nettype wire

// *** core/ppm_pkg.sv ***
package ppm_pkg;
	// Pin slots of the group
	localparam int PIN_COUNT = 10;
	localparam int IDX_C12   = 0;
	localparam int IDX_C13   = 1;
	localparam int IDX_C14   = 2;
	localparam int IDX_C15   = 3;
	localparam int IDX_D0    = 4;
	localparam int IDX_D1    = 5;
	localparam int IDX_D4    = 6;
	localparam int IDX_D5    = 7;
	localparam int IDX_D6    = 8;
	localparam int IDX_D7    = 9;

	// Reset values: only the test data pins and the shared test clock pin start in peripheral function
	localparam logic [9:0] ALT_RESET     = 10'h030;
	localparam logic [9:0] DIR_RESET     = 10'h000;
	localparam logic [9:0] OUT_RESET     = 10'h000;
	localparam logic       TCK_SEL_RESET = 1'h1;

	// Serial receive idles high, external clock idles low
	localparam logic RXD_IDLE = 1'h1;
	localparam logic CLK_IDLE = 1'h0;
	localparam logic TDI_IDLE = 1'h1;

	// Test access port
	localparam int         IR_LEN     = 4;
	localparam logic [3:0] IR_CAPTURE = 4'h1;

	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR,
		TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
		TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
		TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} ppm_tap_state_t;
endpackage

// *** core/ppm_tap_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
module ppm_tap_ctrl
	import ppm_pkg::*;
(
	input  wire logic tck,
	input  wire logic reset_n,
	input  wire logic tms,
	ppm_tap_if.tap    tapIf
);
	ppm_tap_state_t  state_q;
	ppm_tap_state_t  state_d;
	logic [IR_LEN-1:0] ir_q;
	logic              bypass_q;
	logic              selMeta_q;
	logic              sel_q;
	logic              tdo_q;
	logic              tdoEn_q;

	////////////////////////////////////////////////////////////////
	always_comb begin
		unique case (state_q)
			TAP_RESET:    state_d = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE:     state_d = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR:   state_d = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR:   state_d = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: state_d = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: state_d = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: state_d = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: state_d = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR:   state_d = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR:   state_d = tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR:   state_d = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: state_d = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: state_d = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: state_d = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: state_d = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR:   state_d = tms ? TAP_SEL_DR : TAP_IDLE;
		endcase
	end

	// Mode select sampled on the rising test clock
	always_ff @(posedge tck or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= TAP_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// Serial data captured on the rising edge
	always_ff @(posedge tck or negedge reset_n) begin
		if (!reset_n) begin
			ir_q     <= IR_CAPTURE;
			bypass_q <= 1'h0;
		end else begin
			if (state_q == TAP_CAP_IR) begin
				ir_q <= IR_CAPTURE;
			end else if (state_q == TAP_SHIFT_IR) begin
				ir_q <= {tapIf.tdi, ir_q[IR_LEN-1:1]};
			end
			if (state_q == TAP_CAP_DR) begin
				bypass_q <= 1'h0;
			end else if (state_q == TAP_SHIFT_DR) begin
				bypass_q <= tapIf.tdi;
			end
		end
	end

	// Pin select crosses from the system clock
	always_ff @(posedge tck or negedge reset_n) begin
		if (!reset_n) begin
			selMeta_q <= 1'h0;
			sel_q     <= 1'h0;
		end else begin
			selMeta_q <= tapIf.tdoSel;
			sel_q     <= selMeta_q;
		end
	end

	// Output moves on the falling edge so the host has half a period
	always_ff @(negedge tck or negedge reset_n) begin
		if (!reset_n) begin
			tdo_q   <= 1'h0;
			tdoEn_q <= 1'h0;
		end else begin
			tdo_q   <= (state_q == TAP_SHIFT_IR) ? ir_q[0] : bypass_q;
			tdoEn_q <= sel_q && (state_q == TAP_SHIFT_IR ||
				state_q == TAP_SHIFT_DR);
		end
	end

	assign tapIf.tdo   = tdo_q;
	assign tapIf.tdoEn = tdoEn_q;
endmodule
`default_nettype wire

// *** core/ppm_tap_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface ppm_tap_if;
	logic tdi;
	logic tdoSel;
	logic tdo;
	logic tdoEn;
	modport tap (input tdi, input tdoSel, output tdo, output tdoEn);
	modport mux (output tdi, output tdoSel, input tdo, input tdoEn);
endinterface
`default_nettype wire

// *** dv/port_pin_function_mux_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module port_pin_function_mux_tb_top;
	import ppm_pkg::*;
	logic        clk = 1'b0;
	logic        reset_n = 1'b1;
	logic        cfgWrite = 1'b0;
	logic        cfgTestClkSel = 1'b1;
	logic        tck, tms, tdi, testClkSelect;
	logic        serialCh1ReceiveIn, externalClockInput, externalClockSelect;
	logic [9:0]  cfgAlt = 10'h000, cfgDir = 10'h000, cfgOut = 10'h000;
	logic [9:0]  ext = 10'h2DE;
	logic [9:0]  far;
	logic [9:0]  padIn, padOut, padOe, gpioIn, altState;
	logic [15:0] got, gotEn;
	int          n_mismatch = 0, check_count = 0, cycles = 0;
	always #5 clk = ~clk;
	// Undriven test data out pin floats high on its pull-up
	assign far   = {ext[9:6], 1'b1, tdi, ext[3:0]};
	assign padIn = (padOe & padOut) | (~padOe & far);
	ppm_pin_mux i_dut (
		.clk                 (clk),
		.reset_n             (reset_n),
		.tck                 (tck),
		.tms                 (tms),
		.cfgWrite            (cfgWrite),
		.cfgAlt              (cfgAlt),
		.cfgDir              (cfgDir),
		.cfgOut              (cfgOut),
		.cfgTestClkSel       (cfgTestClkSel),
		.padIn               (padIn),
		.padOut              (padOut),
		.padOe               (padOe),
		.gpioIn              (gpioIn),
		.altState            (altState),
		.testClkSelect       (testClkSelect),
		.serialCh1ReceiveIn  (serialCh1ReceiveIn),
		.externalClockInput  (externalClockInput),
		.externalClockSelect (externalClockSelect)
	);
	ppm_jtag_host i_host (.tck(tck), .tms(tms), .tdi(tdi),
		.tdo(padOut[5]), .tdoEn(padOe[5]));
	task automatic check(input logic [15:0] g, e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic cfg(input logic [9:0] a, d, o);
		@(negedge clk);
		{cfgAlt, cfgDir, cfgOut, cfgWrite} = {a, d, o, 1'b1};
		@(negedge clk);
		cfgWrite = 1'b0;
		repeat (4) @(negedge clk);
	endtask
	task automatic test_reset();
		check(16'(altState), 16'(ALT_RESET));
		check(16'(padOe), 16'h0000);
		check(16'({testClkSelect, externalClockSelect, serialCh1ReceiveIn,
			externalClockInput}), 16'h000A);
		check(16'(gpioIn), 16'(far & ~ALT_RESET));
	endtask
	task automatic test_port();
		logic [9:0] d, o;
		cfgTestClkSel = 1'b0;
		for (int k = 0; k < 2; k++) begin
			d = k ? 10'h15A : 10'h2A5;
			o = d ^ 10'h0F0;
			cfg(10'h000, d, o);
			check(16'(padOe), 16'(d));
			check(16'(testClkSelect), 16'h0000);
			check(16'(padOut & d), 16'(o & d));
			check(16'(gpioIn), 16'((d & o) | (~d & far)));
		end
	endtask
	task automatic test_alt();
		cfg(10'h3FF, 10'h3FF, 10'h3FF);
		check(16'(padOe | gpioIn), 16'h0000);
		check(16'({externalClockSelect, serialCh1ReceiveIn,
			externalClockInput}), 16'h0005);
		@(negedge clk) ext = ~ext;
		repeat (4) @(negedge clk);
		check(16'({serialCh1ReceiveIn, externalClockInput}), 16'h0002);
	endtask
	task automatic test_tap();
		i_host.frame(16'h60DF, 16'hFFFF, 16, got, gotEn);
		check(got, 16'hC7FF);
		check(gotEn, 16'h3C00);
		i_host.frame(16'h00C1, 16'hFFEF, 9, got, gotEn);
		check(got, 16'hFFD7);
		check(gotEn, 16'h0078);
	endtask
	task automatic test_midreset();
		i_host.frame(16'h0001, 16'hFFFF, 4, got, gotEn);
		check(got, 16'hFFF7);
		check(gotEn, 16'h0008);
		check(16'(padOe), 16'h0020);
		@(negedge clk) reset_n = 1'b0;
		#1 check(16'(padOe), 16'h0000);
		check(16'(altState), 16'(ALT_RESET));
		repeat (8) @(negedge clk);
		reset_n = 1'b1;
		repeat (4) @(negedge clk);
		test_reset();
		i_host.frame(16'h0032, 16'hFFFF, 7, got, gotEn);
		check(got, 16'hFFEF);
		check(gotEn, 16'h0010);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Run needs about ninety cycles; the ceiling leaves ample margin
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			n_mismatch++;
			test_done();
		end
	end
	initial begin
		// A real falling edge is needed to fire the asynchronous resets
		#1 reset_n = 1'b0;
		repeat (8) @(negedge clk);
		reset_n = 1'b1;
		repeat (4) @(negedge clk);
		test_reset();
		test_port();
		test_alt();
		test_tap();
		test_midreset();
		test_done();
	end
endmodule
`default_nettype wire

// *** dv/ppm_jtag_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module ppm_jtag_host (
	output var logic tck,
	output var logic tms,
	output var logic tdi,
	input  wire logic tdo,
	input  wire logic tdoEn
);
	// Clock stands low outside frames
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	task automatic frame(input logic [15:0] mSeq, dSeq, input int n,
		output logic [15:0] got, gotEn);
		got = 16'hFFFF;
		gotEn = 16'h0000;
		for (int i = 0; i < n; i++) begin
			tms = mSeq[i];
			tdi = dSeq[i];
			#6 tck = 1'b1;
			got[i] = tdoEn ? tdo : 1'b1;
			gotEn[i] = tdoEn;
			#6 tck = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// *** dv/ppm_pin_mux_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module ppm_pin_mux_assertions (
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic       cfgWrite,
	input wire logic [9:0] cfgAlt,
	input wire logic [9:0] cfgDir,
	input wire logic [9:0] cfgOut,
	input wire logic [9:0] padIn,
	input wire logic [9:0] padOut,
	input wire logic [9:0] padOe,
	input wire logic [9:0] gpioIn,
	input wire logic [9:0] altState,
	input wire logic       serialCh1ReceiveIn,
	input wire logic       externalClockInput,
	input wire logic       externalClockSelect
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Sync chains lag three edges, so routes are judged once settled
	sequence s_rx_alt; altState[0] [*4]; endsequence
	sequence s_ck_alt; altState[7] [*4]; endsequence
	a_alt_load: assert property (cfgWrite |=> altState == $past(cfgAlt))
		else $error("select not loaded");
	a_port_oe: assert property ($past(cfgWrite, 2) |->
		(padOe & 10'h3DF) == ($past(cfgDir, 2) & ~$past(cfgAlt, 2) & 10'h3DF))
		else $error("pin enable wrong");
	a_port_out: assert property ($past(cfgWrite, 2) |->
		(padOut & padOe & 10'h3DF) == ($past(cfgOut, 2) & padOe & 10'h3DF))
		else $error("pin output wrong");
	a_rx_route: assert property (s_rx_alt |->
		serialCh1ReceiveIn == $past(padIn[0], 3)) else $error("rx route");
	a_rx_idle: assert property (!altState[0] [*4] |-> serialCh1ReceiveIn)
		else $error("rx not idle");
	a_ck_route: assert property (s_ck_alt |->
		externalClockInput == $past(padIn[7], 3)) else $error("clock route");
	a_ck_idle: assert property (!altState[7] [*4] |-> !externalClockInput)
		else $error("clock not idle");
	a_ck_select: assert property (externalClockSelect == $past(altState[7]))
		else $error("clock select");
	a_gpio_port: assert property (!altState[1] [*4] |->
		gpioIn[1] == $past(padIn[1], 3)) else $error("port input");
	a_gpio_alt: assert property ((gpioIn & altState & $past(altState, 3)) == 0)
		else $error("alt pin seen");
	a_reset_quiet: assert property (@(posedge clk) disable iff (reset_n)
		padOe == 10'h000 && altState == 10'h030) else $error("reset state");
endmodule
bind ppm_pin_mux ppm_pin_mux_assertions i_chk (
	.clk                 (clk),
	.reset_n             (reset_n),
	.cfgWrite            (cfgWrite),
	.cfgAlt              (cfgAlt),
	.cfgDir              (cfgDir),
	.cfgOut              (cfgOut),
	.padIn               (padIn),
	.padOut              (padOut),
	.padOe               (padOe),
	.gpioIn              (gpioIn),
	.altState            (altState),
	.serialCh1ReceiveIn  (serialCh1ReceiveIn),
	.externalClockInput  (externalClockInput),
	.externalClockSelect (externalClockSelect)
);
`default_nettype wire
